// [design/lnb_supply_pkg.sv]
// Package with the constants and carrier types of the antenna supply controller.
package lnb_supply_pkg;

	localparam int unsigned CLOCK_HZ     = 40000000;
	localparam int unsigned LIMIT_WIN_MS = 50;
	localparam int unsigned SHUTDOWN_MS  = 900;
	localparam int unsigned WIN_CYCLES   = CLOCK_HZ / 1000 * LIMIT_WIN_MS;
	localparam int unsigned OFF_CYCLES   = CLOCK_HZ / 1000 * SHUTDOWN_MS;

	// Output voltage codes: 13.5 V, 14.2 V, 18.5 V, 20 V.
	localparam logic [1:0] VOUT_13V5 = 2'h0;
	localparam logic [1:0] VOUT_14V2 = 2'h1;
	localparam logic [1:0] VOUT_18V5 = 2'h2;
	localparam logic [1:0] VOUT_20V0 = 2'h3;

	// Linear limit codes: 11=400 mA, 10=670 mA, 01=790 mA, 00=950 mA.
	localparam logic [1:0] ILIM_400MA = 2'h3;
	localparam logic [1:0] ILIM_670MA = 2'h2;
	localparam logic [1:0] ILIM_790MA = 2'h1;
	localparam logic [1:0] ILIM_950MA = 2'h0;

	// Detector threshold select: 0 = 200 mV receive, 1 = 400 mV transmit.
	localparam logic THRESH_RX_200MV = 1'b0;
	localparam logic THRESH_TX_400MV = 1'b1;

	localparam int unsigned CNT_W = 32;

	typedef struct packed {
		logic tone_force_on;
		logic tone_source_select;
		logic tx_threshold_bit;
		logic boost_on_bit;
		logic linear_on_bit;
		logic range_by_register;
		logic upper_voltage_bit;
		logic lower_voltage_bit;
		logic dynamic_limit_bit;
		logic ilim_code_hi;
		logic ilim_code_lo;
	} ctrl_type;

	typedef struct packed {
		logic overtemp_flag;
		logic cable_loss_flag;
		logic out_range_flag;
		logic overload_flag;
		logic back_bias_flag;
	} status_type;

	typedef struct packed {
		logic linear_limit;
		logic overtemp_hot;
		logic overtemp_cool;
		logic out_not_in_reg;
		logic back_bias_det;
		logic load_below_50ma;
		logic supply_lockout;
		logic tone_detected;
	} sense_type;

	typedef enum logic [1:0] {
		LIM_NORMAL,
		LIM_WINDOW,
		LIM_OFF
	} limit_state_type;

	// Register offsets on APB.
	localparam logic [11:0] OFF_CTRL   = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_DRIVE  = 12'h008;

	// Bit positions inside the control word.
	localparam int unsigned B_FORCE = 0;
	localparam int unsigned B_SRC   = 1;
	localparam int unsigned B_TTH   = 2;
	localparam int unsigned B_BOOST = 3;
	localparam int unsigned B_LIN   = 4;
	localparam int unsigned B_RANGE = 5;
	localparam int unsigned B_UPPER = 6;
	localparam int unsigned B_LOWER = 7;
	localparam int unsigned B_DYN   = 8;
	localparam int unsigned B_ILHI  = 9;
	localparam int unsigned B_ILLO  = 10;

	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// [design/lnb_supply_control.sv]
// Control logic of a single-output antenna supply with APB register access.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps

// Behaviour
// - Source select alone passes external modulation.
// - Force on (select low) injects tone when external low.
// - Both zero: external high gates internal tone.
// - Detected tone pulls detect output low.
// - Threshold 200mV receive, 400mV if either set.
// - Transmit switch on when pin or bit set.
// - Decode boost and linear enable bits.
// - Pin mode: pin picks range, bits pick level.
// - Register mode: two bits pick four voltages.
// - Two-bit code sets linear current limit.
// - Linear limit sets overload; boost limit does not.
// - Dynamic: full current 50ms, clear if ends.
// - Dynamic persist: off 900ms, then retry.
// - Static: stay on, overload high while overcurrent.
// - Overtemp disables stages until cool recovery.
// - Any flag drives fault pin low.
// - Out-of-range flag high until back in regulation.
// - Tone allowed only after in range; latch low.
// - Back-bias detector sets its flag.
// - Cable loss from 50mA load comparison.
// - Flags except overtemp inactive until linear stage enabled.
// - Supply lockout holds both stages off.
// - Limit codes 400/670/790/950 mA.
module lnb_supply_control #(
	parameter int unsigned WIN_COUNT = lnb_supply_pkg::WIN_CYCLES,
	parameter int unsigned OFF_COUNT = lnb_supply_pkg::OFF_CYCLES
) (
	// Clock and reset.
	input  wire logic                      clock_i,
	input  wire logic                      nrst_i,
	// APB slave.
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [11:0]               paddr_i,
	input  wire logic [31:0]               pwdata_i,
	input  wire logic [3:0]                pstrb_i,
	output logic      [31:0]               prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	// Device pins and analog sense.
	input  wire logic                      ext_modulation_in_i,
	input  wire logic                      transmit_pin_i,
	input  wire logic                      high_range_pin_i,
	input  wire lnb_supply_pkg::sense_type sense_i,
	// Controls to the analog blocks.
	output logic                           tone_internal_o,
	output logic                           tone_external_o,
	output logic                           detect_threshold_o,
	output logic                           tx_switch_on_o,
	output logic                           boost_enable_o,
	output logic                           linear_enable_o,
	output logic      [1:0]                vout_code_o,
	output logic      [1:0]                ilim_code_o,
	output logic                           constant_current_o,
	// Open-drain pins and the status flags.
	output logic                           tone_detect_out_n_o,
	output logic                           tone_detect_out_n_oe_o,
	output logic                           fault_pin_n_o,
	output logic                           fault_pin_n_oe_o,
	output lnb_supply_pkg::status_type     status_o
);
	import lnb_supply_pkg::*;

	// The bounds are taken at 64 bits so that a full-width counter does not wrap the limit.
	if (WIN_COUNT < 1 || OFF_COUNT < 1
		|| longint'(WIN_COUNT) >= (longint'(1) << CNT_W)
		|| longint'(OFF_COUNT) >= (longint'(1) << CNT_W)) begin : g_bad_counts
		$error("Interval counts must lie between one and the counter range.");
	end

	typedef struct packed {
		ctrl_type        ctrl;
		status_type      flags;
		limit_state_type lim;
		logic [CNT_W-1:0] count;
		logic            tone_latch;
		logic            hot;
		logic            tone_det;
		logic            int_tone;
		logic            ext_tone;
		logic            thresh;
		logic            txsw;
		logic            boost_en;
		logic            lin_en;
		logic [1:0]      vout;
		logic [1:0]      ilim;
		logic            cc;
	} state_type;

	state_type state;
	state_type next_state;

	logic        bus_write;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_drive;
	logic [31:0] ctrl_word;
	logic [31:0] drive_word;

	assign bus_write  = psel_i && penable_i && pwrite_i;
	assign hit_ctrl   = paddr_i == OFF_CTRL;
	assign hit_status = paddr_i == OFF_STATUS;
	assign hit_drive  = paddr_i == OFF_DRIVE;
	assign pready_o   = 1'b1;
	assign pslverr_o  = psel_i && penable_i && !(hit_ctrl || hit_status || hit_drive);

	always_comb begin
		ctrl_word         = ZERO_WORD;
		ctrl_word[B_FORCE] = state.ctrl.tone_force_on;
		ctrl_word[B_SRC]   = state.ctrl.tone_source_select;
		ctrl_word[B_TTH]   = state.ctrl.tx_threshold_bit;
		ctrl_word[B_BOOST] = state.ctrl.boost_on_bit;
		ctrl_word[B_LIN]   = state.ctrl.linear_on_bit;
		ctrl_word[B_RANGE] = state.ctrl.range_by_register;
		ctrl_word[B_UPPER] = state.ctrl.upper_voltage_bit;
		ctrl_word[B_LOWER] = state.ctrl.lower_voltage_bit;
		ctrl_word[B_DYN]   = state.ctrl.dynamic_limit_bit;
		ctrl_word[B_ILHI]  = state.ctrl.ilim_code_hi;
		ctrl_word[B_ILLO]  = state.ctrl.ilim_code_lo;
		drive_word         = {18'h00000, state.cc, state.ilim, state.vout, state.lin_en,
			state.boost_en, state.txsw, state.thresh, state.ext_tone, state.int_tone,
			state.tone_det, state.lim};
		if (hit_ctrl) begin
			prdata_o = ctrl_word;
		end else if (hit_status) begin
			prdata_o = {27'h0000000, state.flags};
		end else if (hit_drive) begin
			prdata_o = drive_word;
		end else begin
			prdata_o = ZERO_WORD;
		end
	end

	always_comb begin
		logic on_ok;
		logic tone_req;
		logic tone_ok;
		logic in_limit;
		on_ok    = 1'b0;
		tone_req = 1'b0;
		tone_ok  = 1'b0;
		in_limit = 1'b0;
		next_state = state;

		// Only the low byte and byte one hold control bits, so those lanes gate the write.
		if (bus_write && hit_ctrl) begin
			if (pstrb_i[0]) begin
				next_state.ctrl.tone_force_on      = pwdata_i[B_FORCE];
				next_state.ctrl.tone_source_select = pwdata_i[B_SRC];
				next_state.ctrl.tx_threshold_bit   = pwdata_i[B_TTH];
				next_state.ctrl.boost_on_bit       = pwdata_i[B_BOOST];
				next_state.ctrl.linear_on_bit      = pwdata_i[B_LIN];
				next_state.ctrl.range_by_register  = pwdata_i[B_RANGE];
				next_state.ctrl.upper_voltage_bit  = pwdata_i[B_UPPER];
				next_state.ctrl.lower_voltage_bit  = pwdata_i[B_LOWER];
			end
			if (pstrb_i[1]) begin
				next_state.ctrl.dynamic_limit_bit = pwdata_i[B_DYN];
				next_state.ctrl.ilim_code_hi      = pwdata_i[B_ILHI];
				next_state.ctrl.ilim_code_lo      = pwdata_i[B_ILLO];
			end
		end

		// Over-temperature trips at once and holds until the cool indication.
		if (sense_i.overtemp_hot) begin
			next_state.hot = 1'b1;
		end else if (sense_i.overtemp_cool) begin
			next_state.hot = 1'b0;
		end

		in_limit = sense_i.linear_limit && state.lin_en;
		unique case (state.lim)
			LIM_NORMAL: begin
				if (in_limit && state.ctrl.dynamic_limit_bit) begin
					next_state.lim   = LIM_WINDOW;
					next_state.count = CNT_W'(WIN_COUNT - 1);
				end
			end
			// Leaving dynamic mode abandons the sequence, so static limiting keeps the output on.
			LIM_WINDOW: begin
				if (!in_limit || !state.ctrl.dynamic_limit_bit) begin
					next_state.lim = LIM_NORMAL;
				end else if (state.count == '0) begin
					next_state.lim   = LIM_OFF;
					next_state.count = CNT_W'(OFF_COUNT - 1);
				end else begin
					next_state.count = state.count - 1'b1;
				end
			end
			LIM_OFF: begin
				if (state.count == '0 || !state.ctrl.dynamic_limit_bit) begin
					next_state.lim = LIM_NORMAL;
				end else begin
					next_state.count = state.count - 1'b1;
				end
			end
		endcase

		on_ok = !sense_i.supply_lockout && !state.hot && state.lim != LIM_OFF;
		next_state.boost_en = on_ok && state.ctrl.boost_on_bit;
		next_state.lin_en   = on_ok && state.ctrl.boost_on_bit && state.ctrl.linear_on_bit;

		if (state.ctrl.range_by_register) begin
			next_state.vout = {state.ctrl.upper_voltage_bit, state.ctrl.lower_voltage_bit};
		end else if (high_range_pin_i) begin
			next_state.vout = state.ctrl.upper_voltage_bit ? VOUT_20V0 : VOUT_18V5;
		end else begin
			next_state.vout = state.ctrl.lower_voltage_bit ? VOUT_14V2 : VOUT_13V5;
		end

		// The code maps straight onto the analog selector: 11=400, 10=670, 01=790, 00=950 mA.
		next_state.ilim = {state.ctrl.ilim_code_hi, state.ctrl.ilim_code_lo};
		next_state.cc   = !state.ctrl.dynamic_limit_bit && in_limit;

		next_state.txsw   = transmit_pin_i || state.ctrl.tx_threshold_bit;
		next_state.thresh = next_state.txsw ? THRESH_TX_400MV : THRESH_RX_200MV;
		next_state.tone_det = sense_i.tone_detected;

		if (state.ctrl.tone_force_on) begin
			tone_req = !state.ctrl.tone_source_select && !ext_modulation_in_i;
		end else if (state.ctrl.tone_source_select) begin
			tone_req = ext_modulation_in_i;
		end else begin
			tone_req = ext_modulation_in_i;
		end
		tone_ok = state.lin_en && (!state.flags.out_range_flag || state.tone_latch);
		next_state.tone_latch = tone_ok && tone_req;
		next_state.int_tone = tone_ok && tone_req && !state.ctrl.tone_source_select;
		next_state.ext_tone = tone_ok && tone_req && state.ctrl.tone_source_select
			&& !state.ctrl.tone_force_on;

		if (!state.lin_en) begin
			next_state.flags = '0;
		end else begin
			next_state.flags.overtemp_flag   = state.hot;
			next_state.flags.cable_loss_flag = sense_i.load_below_50ma;
			next_state.flags.back_bias_flag  = sense_i.back_bias_det;
			next_state.flags.out_range_flag  = sense_i.out_not_in_reg && !state.tone_latch;
			next_state.flags.overload_flag   = in_limit;
		end
		// Overtemp must stay visible even though it turns the linear stage off.
		if (state.hot) begin
			next_state.flags.overtemp_flag = 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tone_internal_o        = state.int_tone;
	assign tone_external_o        = state.ext_tone;
	assign detect_threshold_o     = state.thresh;
	assign tx_switch_on_o         = state.txsw;
	assign boost_enable_o         = state.boost_en;
	assign linear_enable_o        = state.lin_en;
	assign vout_code_o            = state.vout;
	assign ilim_code_o            = state.ilim;
	assign constant_current_o     = state.cc;
	assign tone_detect_out_n_o    = 1'b0;
	assign tone_detect_out_n_oe_o = state.tone_det;
	assign fault_pin_n_o          = 1'b0;
	assign fault_pin_n_oe_o       = |state.flags;
	assign status_o               = state.flags;

	a_lockout_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sense_i.supply_lockout |=> !boost_enable_o && !linear_enable_o)
		else $error("Stage on during supply lockout.");

	a_fault_pin: assert property (@(posedge clock_i) disable iff (!nrst_i)
		fault_pin_n_oe_o == (|status_o))
		else $error("Fault pin does not follow the flags.");

	logic in_limit_q;
	assign in_limit_q = sense_i.linear_limit && state.lin_en;

	// The stage enables are registered, so the shutdown shows one cycle after the state change.
	a_window_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.lim == LIM_WINDOW && state.count == '0 && in_limit_q && state.ctrl.dynamic_limit_bit
		|=> ##1 !boost_enable_o && !linear_enable_o)
		else $error("Stages not off after the window.");

	a_range_reg: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.ctrl.range_by_register |=> vout_code_o ==
		$past({state.ctrl.upper_voltage_bit, state.ctrl.lower_voltage_bit}))
		else $error("Register voltage code wrong.");

	a_thresh_tx: assert property (@(posedge clock_i) disable iff (!nrst_i)
		transmit_pin_i |=> detect_threshold_o == THRESH_TX_400MV && tx_switch_on_o)
		else $error("Transmit threshold not chosen.");

	a_flags_idle: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!linear_enable_o && !state.hot |=> status_o == '0)
		else $error("Flags active with linear stage off.");

	a_hot_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sense_i.overtemp_hot |=> ##1 !boost_enable_o && status_o.overtemp_flag)
		else $error("Overtemperature did not shut down.");

	a_static_cc: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.dynamic_limit_bit && in_limit_q && linear_enable_o |=> constant_current_o
		&& status_o.overload_flag)
		else $error("Static limit not held.");

	a_tone_gate: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.tone_latch && status_o.out_range_flag |=> !tone_internal_o && !tone_external_o)
		else $error("Tone out before output in range.");

	a_tone_ext_src: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.tone_force_on && state.ctrl.tone_source_select && ext_modulation_in_i
		&& state.lin_en && !state.flags.out_range_flag |=> tone_external_o && !tone_internal_o)
		else $error("External tone not passed.");

	a_tone_forced: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.ctrl.tone_force_on && !state.ctrl.tone_source_select && !ext_modulation_in_i
		&& state.lin_en && !state.flags.out_range_flag |=> tone_internal_o)
		else $error("Forced internal tone missing.");

	a_tone_gated: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.tone_force_on && !state.ctrl.tone_source_select && !ext_modulation_in_i
		|=> !tone_internal_o && !tone_external_o)
		else $error("Tone out while the gate pin is low.");

	a_detect_pin: assert property (@(posedge clock_i) disable iff (!nrst_i)
		sense_i.tone_detected |=> tone_detect_out_n_oe_o)
		else $error("Detect output not pulled low.");

	a_rx_thresh: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!transmit_pin_i && !state.ctrl.tx_threshold_bit
		|=> detect_threshold_o == THRESH_RX_200MV && !tx_switch_on_o)
		else $error("Receive threshold not chosen.");

	a_boost_only: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.linear_on_bit |=> !linear_enable_o)
		else $error("Linear stage on without its bit.");

	a_stages_off: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.boost_on_bit |=> !boost_enable_o && !linear_enable_o)
		else $error("Stage on with both bits low.");

	a_range_pin: assert property (@(posedge clock_i) disable iff (!nrst_i)
		!state.ctrl.range_by_register |=> vout_code_o[1] == $past(high_range_pin_i))
		else $error("Range pin not followed.");

	a_ilim_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.ctrl.ilim_code_hi && state.ctrl.ilim_code_lo |=> ilim_code_o == ILIM_400MA)
		else $error("Lowest limit code wrong.");

	a_overload_set: assert property (@(posedge clock_i) disable iff (!nrst_i)
		in_limit_q |=> status_o.overload_flag)
		else $error("Overload not flagged.");

	a_window_clear: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.lim == LIM_WINDOW && !in_limit_q
		|=> !status_o.overload_flag && state.lim == LIM_NORMAL)
		else $error("Window did not clear on recovery.");

	a_off_retry: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.lim == LIM_OFF && state.count == '0 |=> state.lim == LIM_NORMAL)
		else $error("No restart after the off time.");

	a_hot_hold: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.hot |=> !boost_enable_o && !linear_enable_o && status_o.overtemp_flag)
		else $error("Stages on while hot.");

	a_range_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
		linear_enable_o && sense_i.out_not_in_reg && !state.tone_latch
		|=> status_o.out_range_flag)
		else $error("Out of range not flagged.");

	a_tone_latch: assert property (@(posedge clock_i) disable iff (!nrst_i)
		state.tone_latch |=> !status_o.out_range_flag)
		else $error("Range flag rose during tone.");

	a_bias_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
		linear_enable_o && sense_i.back_bias_det |=> status_o.back_bias_flag)
		else $error("Back bias not flagged.");

	a_cable_flag: assert property (@(posedge clock_i) disable iff (!nrst_i)
		linear_enable_o && sense_i.load_below_50ma |=> status_o.cable_loss_flag)
		else $error("Cable loss not flagged.");

endmodule

// [dv/lnb_model.sv]
// Behavioural model of the low-noise block and cable seen by the supply controller.
`timescale 1ns/10ps
module lnb_model (
	// Clock and reset.
	input  wire logic                      clock_i,
	input  wire logic                      nrst_i,
	// Supply state from the controller.
	input  wire logic                      linear_enable_i,
	input  wire logic                      tone_on_i,
	// Conditions commanded by the bench.
	input  wire lnb_supply_pkg::sense_type request_i,
	// Sensed conditions back to the controller.
	output lnb_supply_pkg::sense_type      sense_o
);
	import lnb_supply_pkg::*;

	// A dead output draws no current, so an overload needs a live linear stage.
	// Our own transmitted tone also reaches the detector, as on a real cable.
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			sense_o <= '0;
		end else begin
			sense_o <= request_i;
			sense_o.linear_limit <= request_i.linear_limit & linear_enable_i;
			sense_o.load_below_50ma <= request_i.load_below_50ma | !linear_enable_i;
			sense_o.tone_detected <= request_i.tone_detected | tone_on_i;
		end
	end
endmodule

// [dv/tb_top.sv]
// Self-checking bench for the antenna supply controller.
`timescale 1ns/10ps
module tb_top;
	import lnb_supply_pkg::*;
	localparam int unsigned WIN = 20;
	localparam int unsigned OFF = 40;
	localparam int          LIMIT = 5000;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, cw;
	logic        ext, txp, hip, t_int, t_ext, thr, tx_sw, b_en, l_en, cc, det_oe, flt_oe;
	logic [1:0]  vout, ilim;
	sense_type   req, sense;
	status_type  st;
	ctrl_type    c;
	int          bad_count, n_tests, cycles;

	lnb_supply_control #(.WIN_COUNT(WIN), .OFF_COUNT(OFF)) i_lnb_supply_control (
		.clock_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.ext_modulation_in_i(ext), .transmit_pin_i(txp), .high_range_pin_i(hip),
		.sense_i(sense), .tone_internal_o(t_int), .tone_external_o(t_ext),
		.detect_threshold_o(thr), .tx_switch_on_o(tx_sw), .boost_enable_o(b_en),
		.linear_enable_o(l_en), .vout_code_o(vout), .ilim_code_o(ilim),
		.constant_current_o(cc), .tone_detect_out_n_o(),
		.tone_detect_out_n_oe_o(det_oe), .fault_pin_n_o(), .fault_pin_n_oe_o(flt_oe),
		.status_o(st));

	lnb_model i_lnb_model (
		.clock_i(clk), .nrst_i(nrst), .linear_enable_i(l_en),
		.tone_on_i(t_int | t_ext), .request_i(req), .sense_o(sense));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk1(input string nm, input logic e, input logic s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask

	// The request is held until pready is seen high, whatever the slave's latency.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// The slave has no wait states, so the first access cycle completes.
		chkw("latency", 32'h1, n);
	endtask

	// The register puts the first field of the struct at bit 0, hence the reversal.
	task automatic put_ctrl;
		logic [10:0] w;
		w = {<<{c}};
		cw = {21'h0, w};
		apb(1'b1, OFF_CTRL, cw);
		wt(4);
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			tally_and_finish();
		end
	end

	initial begin
		{nrst, psel, penable, pwrite, ext, txp, hip, err} = '0;
		paddr = '0;
		pwdata = '0;
		req = '0;
		c = '0;
		{bad_count, n_tests, cycles} = '0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, OFF_CTRL, ZERO_WORD);
		chkw("ctrl", 32'h0, rd);
		chkw("stages", 32'h0, {30'h0, b_en, l_en});
		fin("reset");
		c.boost_on_bit = 1'b1;
		c.linear_on_bit = 1'b1;
		for (int i = 0; i < 8; i++) begin
			c.tone_force_on = i[2];
			c.tone_source_select = i[1];
			ext <= i[0];
			put_ctrl();
			chk1("tone_int", (i[2] & ~i[1] & ~i[0]) | (~i[2] & ~i[1] & i[0]), t_int);
			if (i[0]) begin
				chk1("tone_ext", ~i[2] & i[1], t_ext);
			end
		end
		c.tone_force_on = 1'b0;
		c.tone_source_select = 1'b0;
		ext <= 1'b0;
		put_ctrl();
		req.out_not_in_reg <= 1'b1;
		wt(4);
		chk1("out_range", 1'b1, st.out_range_flag);
		ext <= 1'b1;
		wt(4);
		chk1("tone_int", 1'b0, t_int);
		req.out_not_in_reg <= 1'b0;
		wt(4);
		chk1("tone_int", 1'b1, t_int);
		req.out_not_in_reg <= 1'b1;
		wt(4);
		chk1("out_range", 1'b0, st.out_range_flag);
		ext <= 1'b0;
		wt(4);
		chk1("out_range", 1'b1, st.out_range_flag);
		req.out_not_in_reg <= 1'b0;
		fin("tone");
		for (int i = 0; i < 4; i++) begin
			c.tx_threshold_bit = i[1];
			txp <= i[0];
			put_ctrl();
			chk1("threshold", i != 0, thr);
			chk1("tx_switch", i != 0, tx_sw);
		end
		for (int i = 0; i < 4; i++) begin
			c.boost_on_bit = i[1];
			c.linear_on_bit = i[0];
			put_ctrl();
			chkw("stages", {30'h0, i[1], i[1] & i[0]}, {30'h0, b_en, l_en});
		end
		req.supply_lockout <= 1'b1;
		wt(4);
		chkw("stages", 32'h0, {30'h0, b_en, l_en});
		req.supply_lockout <= 1'b0;
		wt(4);
		chkw("stages", 32'h3, {30'h0, b_en, l_en});
		fin("power");
		for (int i = 0; i < 16; i++) begin
			c.range_by_register = i[3];
			c.upper_voltage_bit = i[2];
			c.lower_voltage_bit = i[1];
			hip <= i[0];
			put_ctrl();
			chkw("vout", {30'h0, i[3] ? i[2:1] : (i[0] ? {1'b1, i[2]} : {1'b0, i[1]})},
				{30'h0, vout});
		end
		for (int i = 0; i < 4; i++) begin
			c.ilim_code_hi = i[1];
			c.ilim_code_lo = i[0];
			put_ctrl();
			chkw("ilim", {30'h0, (i == 3) ? ILIM_400MA : (i == 2) ? ILIM_670MA
				: (i == 1) ? ILIM_790MA : ILIM_950MA}, {30'h0, ilim});
		end
		fin("codes");
		c.dynamic_limit_bit = 1'b1;
		put_ctrl();
		req.linear_limit <= 1'b1;
		wt(10);
		chkw("overload", 32'h7, {29'h0, st.overload_flag, l_en, flt_oe});
		req.linear_limit <= 1'b0;
		wt(4);
		chkw("recover", 32'h2, {29'h0, st.overload_flag, l_en, flt_oe});
		req.linear_limit <= 1'b1;
		wt(WIN + 6);
		chkw("shutdown", 32'h0, {30'h0, b_en, l_en});
		wt(OFF - 12);
		chkw("shutdown", 32'h0, {30'h0, b_en, l_en});
		wt(12);
		chkw("retry", 32'h3, {30'h0, b_en, l_en});
		c.dynamic_limit_bit = 1'b0;
		put_ctrl();
		wt(WIN + 10);
		chkw("static", 32'h7, {29'h0, st.overload_flag, l_en, cc});
		req.linear_limit <= 1'b0;
		wt(4);
		chkw("static", 32'h0, {30'h0, st.overload_flag, flt_oe});
		fin("limit");
		req.overtemp_hot <= 1'b1;
		wt(4);
		chkw("hot", 32'h4, {29'h0, st.overtemp_flag, b_en, l_en});
		req.overtemp_hot <= 1'b0;
		wt(4);
		chkw("hot", 32'h4, {29'h0, st.overtemp_flag, b_en, l_en});
		req.overtemp_cool <= 1'b1;
		wt(4);
		chkw("cool", 32'h3, {29'h0, st.overtemp_flag, b_en, l_en});
		req.overtemp_cool <= 1'b0;
		req.back_bias_det <= 1'b1;
		wt(4);
		chkw("bias", 32'h3, {30'h0, st.back_bias_flag, flt_oe});
		apb(1'b0, OFF_STATUS, ZERO_WORD);
		chkw("status", 32'h1, rd);
		c.linear_on_bit = 1'b0;
		put_ctrl();
		chkw("flags", 32'h0, {27'h0, st});
		chk1("fault", 1'b0, flt_oe);
		req.back_bias_det <= 1'b0;
		c.linear_on_bit = 1'b1;
		put_ctrl();
		req.load_below_50ma <= 1'b1;
		wt(4);
		apb(1'b0, OFF_STATUS, ZERO_WORD);
		chkw("status", 32'h8, rd);
		req.load_below_50ma <= 1'b0;
		wt(4);
		chk1("cable", 1'b0, st.cable_loss_flag);
		req.tone_detected <= 1'b1;
		wt(4);
		chk1("detect", 1'b1, det_oe);
		req.tone_detected <= 1'b0;
		wt(4);
		chk1("detect", 1'b0, det_oe);
		fin("flags");
		apb(1'b0, 12'h00C, ZERO_WORD);
		chkw("unmapped", 32'h1, {rd[30:0], err});
		apb(1'b1, OFF_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, OFF_STATUS, ZERO_WORD);
		chkw("status_ro", 32'h0, rd);
		apb(1'b0, OFF_CTRL, ZERO_WORD);
		chkw("ctrl", cw, rd);
		fin("bus");
		tally_and_finish();
	end
endmodule
